// ==== verilog/scp_pkg.sv ====
// Shared constants and the address function of the two-wire serial control port
// ====================================================================
// Operation
// - Both straps high selects four-wire port
// - Address 1011 plus three times upper plus lower
// - Bus clock at most fast-mode rate
// - Device never drives clock, samples master pulses
// - Data changes only while clock low
// - Start and stop edges while clock high
// - Eight bits, MSB first, then acknowledge
// - Ninth pulse low acknowledges, high refuses
// - Master sends seven-bit address plus direction
// - Acknowledge only own address, else idle
// - Two register address bytes, high first
// - Later write bytes stored as register data
// - Unlimited bytes per transfer both directions
// - Read drives register data after address
// - Read refusal ends transfer, releases data
// - Master stops after last write acknowledge
// - Repeated start re-evaluates the address byte
// - Start or stop anywhere discards partial byte
// - Port stays active during sleep
// - Address-only write keeps the register pointer
// - Plain read starts at current pointer
package scp_pkg;
   // ====================================================================
   // Addressing
   localparam logic [3:0] SCP_ADDR_UPPER = 4'hB;
   localparam logic [1:0] SCP_STRAP_LOW = 2'h0;
   localparam logic [1:0] SCP_STRAP_OPEN = 2'h1;
   localparam logic [1:0] SCP_STRAP_HIGH = 2'h2;
   localparam logic SCP_DIR_WRITE = 1'b0;
   localparam logic SCP_DIR_READ = 1'b1;
   localparam logic [1:0] SCP_IDX_SLAVE = 2'h0;
   localparam logic [1:0] SCP_IDX_HI = 2'h1;
   localparam logic [1:0] SCP_IDX_LO = 2'h2;
   localparam logic [1:0] SCP_IDX_DATA = 2'h3;
   localparam logic [3:0] SCP_BITS_PER_BYTE = 4'h8;
   localparam logic [3:0] SCP_LAST_BIT = 4'h7;
   localparam logic [15:0] SCP_PTR_STEP = 16'h0001;
   // ====================================================================
   // Timing
   localparam int SCP_REF_CLK_KHZ = 40000;
   localparam int SCP_SCL_STD_KHZ = 100;
   localparam int SCP_SCL_FAST_KHZ = 400;
   // Rounded up so the generated clock never exceeds the fast-mode rate
   localparam int SCP_QUARTER_CYC = (SCP_REF_CLK_KHZ + 4 * SCP_SCL_FAST_KHZ - 1) / (4 * SCP_SCL_FAST_KHZ);
   localparam logic [7:0] SCP_QUARTER_LAST = 8'(SCP_QUARTER_CYC - 1);

   function automatic logic [6:0] scp_slave_addr(input logic [1:0] upper, input logic [1:0] lower);
      logic [2:0] low3;
      low3 = 3'h3 * {1'b0, upper} + {1'b0, lower};
      return {SCP_ADDR_UPPER, low3};
   endfunction
endpackage

// ==== verilog/scp_if.sv ====
// Two-wire bus carrier joining master and slave ends
`timescale 1ns/1ps
interface scp_if;
   logic scl_o;
   logic scl_oe;
   logic sda_m_o;
   logic sda_m_oe;
   logic sda_s_o;
   logic sda_s_oe;
   logic scl;
   logic sda;
   // ====================================================================
   // Wired-and with pull-ups: a released line reads high
   assign scl = !(scl_oe && !scl_o);
   assign sda = !(sda_m_oe && !sda_m_o) && !(sda_s_oe && !sda_s_o);
   modport dev (input scl, input sda, output sda_s_o, output sda_s_oe);
   modport host (input sda, output scl_o, output scl_oe, output sda_m_o, output sda_m_oe);
endinterface

// ==== verilog/scp_dev.sv ====
// Slave end of the two-wire serial control port
`timescale 1ns/1ps
module scp_dev
   import scp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   scp_if.dev bus,
   input wire logic [1:0] port_strap_upper,
   input wire logic [1:0] port_strap_lower,
   input wire logic sleep_request_n,
   output logic four_wire_sel,
   output logic sleep_active,
   output logic [15:0] reg_addr,
   output logic [7:0] reg_wdata,
   output logic reg_wr_stb,
   output logic reg_rd_stb,
   input wire logic [7:0] reg_rdata
);
   // ====================================================================
   // State
   typedef enum logic [2:0] {DS_IDLE, DS_RX, DS_RX_ACK, DS_TX, DS_TX_ACK} scp_dev_st_t;

   typedef struct packed {
      logic scl_s1;
      logic scl_s2;
      logic scl_q;
      logic sda_s1;
      logic sda_s2;
      logic sda_q;
      logic [1:0] up_s1;
      logic [1:0] up_s2;
      logic [1:0] lo_s1;
      logic [1:0] lo_s2;
      logic slp_s1;
      logic slp_s2;
      scp_dev_st_t st;
      logic [3:0] bit_cnt;
      logic [1:0] byte_idx;
      logic dir;
      logic [7:0] shreg;
      logic [15:0] ptr;
      logic [7:0] wdata;
      logic wr_stb;
      logic rd_stb;
      logic sda_low;
      logic mack;
   } scp_dev_reg_t;

   // Line and sleep samples start at their idle high level so no false edge follows reset
   localparam scp_dev_reg_t SCP_DEV_RST = '{scl_s1: 1'b1, scl_s2: 1'b1, scl_q: 1'b1, sda_s1: 1'b1, sda_s2: 1'b1,
      sda_q: 1'b1, slp_s1: 1'b1, slp_s2: 1'b1, st: DS_IDLE, default: '0};

   scp_dev_reg_t r;
   scp_dev_reg_t n;
   logic scl_rise;
   logic scl_fall;
   logic start_det;
   logic stop_det;
   logic i2c_en;
   logic [6:0] my_addr;
   logic load_tx;

   // ====================================================================
   // Bus conditions, seen only through the second synchroniser stage
   assign scl_rise = r.scl_s2 && !r.scl_q;
   assign scl_fall = !r.scl_s2 && r.scl_q;
   assign start_det = r.scl_s2 && r.scl_q && r.sda_q && !r.sda_s2;
   assign stop_det = r.scl_s2 && r.scl_q && !r.sda_q && r.sda_s2;
   assign i2c_en = !(r.up_s2 == SCP_STRAP_HIGH && r.lo_s2 == SCP_STRAP_HIGH);
   assign my_addr = scp_slave_addr(r.up_s2, r.lo_s2);

   // ====================================================================
   // Next state
   always_comb
   begin
      n = r;
      load_tx = 1'b0;
      n.scl_s1 = bus.scl;
      n.scl_s2 = r.scl_s1;
      n.scl_q = r.scl_s2;
      n.sda_s1 = bus.sda;
      n.sda_s2 = r.sda_s1;
      n.sda_q = r.sda_s2;
      n.up_s1 = port_strap_upper;
      n.up_s2 = r.up_s1;
      n.lo_s1 = port_strap_lower;
      n.lo_s2 = r.lo_s1;
      n.slp_s1 = sleep_request_n;
      n.slp_s2 = r.slp_s1;
      n.wr_stb = 1'b0;
      n.rd_stb = 1'b0;
      // Pointer steps once the strobe cycle has shown the accessed address
      if (r.wr_stb || r.rd_stb)
      begin
         n.ptr = r.ptr + SCP_PTR_STEP;
      end
      // Sleep does not gate the port; only the strap mode does
      if (!i2c_en || stop_det)
      begin
         n.st = DS_IDLE;
         n.sda_low = 1'b0;
      end
      else if (start_det)
      begin
         n.st = DS_RX;
         n.bit_cnt = 4'h0;
         n.byte_idx = SCP_IDX_SLAVE;
         n.sda_low = 1'b0;
      end
      else
      begin
         case (r.st)
            DS_RX:
            begin
               if (scl_rise)
               begin
                  n.shreg = {r.shreg[6:0], r.sda_s2};
                  n.bit_cnt = r.bit_cnt + 4'h1;
               end
               else if (scl_fall && r.bit_cnt == SCP_BITS_PER_BYTE)
               begin
                  n.bit_cnt = 4'h0;
                  n.st = DS_RX_ACK;
                  n.sda_low = 1'b1;
                  case (r.byte_idx)
                     SCP_IDX_SLAVE:
                     begin
                        if (r.shreg[7:1] == my_addr)
                        begin
                           n.dir = r.shreg[0];
                           n.byte_idx = (r.shreg[0] == SCP_DIR_READ) ? SCP_IDX_DATA : SCP_IDX_HI;
                        end
                        else
                        begin
                           n.st = DS_IDLE;
                           n.sda_low = 1'b0;
                        end
                     end
                     SCP_IDX_HI:
                     begin
                        n.ptr[15:8] = r.shreg;
                        n.byte_idx = SCP_IDX_LO;
                     end
                     SCP_IDX_LO:
                     begin
                        n.ptr[7:0] = r.shreg;
                        n.byte_idx = SCP_IDX_DATA;
                     end
                     default:
                     begin
                        n.wdata = r.shreg;
                        n.wr_stb = 1'b1;
                     end
                  endcase
               end
            end
            DS_RX_ACK:
            begin
               if (scl_fall)
               begin
                  n.sda_low = 1'b0;
                  if (r.dir == SCP_DIR_READ)
                  begin
                     load_tx = 1'b1;
                  end
                  else
                  begin
                     n.st = DS_RX;
                  end
               end
            end
            DS_TX:
            begin
               if (scl_fall)
               begin
                  if (r.bit_cnt == SCP_LAST_BIT)
                  begin
                     n.sda_low = 1'b0;
                     n.bit_cnt = 4'h0;
                     n.st = DS_TX_ACK;
                  end
                  else
                  begin
                     n.shreg = {r.shreg[6:0], 1'b0};
                     n.sda_low = !r.shreg[6];
                     n.bit_cnt = r.bit_cnt + 4'h1;
                  end
               end
            end
            DS_TX_ACK:
            begin
               if (scl_rise)
               begin
                  n.mack = !r.sda_s2;
               end
               else if (scl_fall)
               begin
                  if (r.mack)
                  begin
                     load_tx = 1'b1;
                  end
                  else
                  begin
                     n.st = DS_IDLE;
                  end
               end
            end
            default:
            begin
               n.st = DS_IDLE;
            end
         endcase
      end
      if (load_tx)
      begin
         n.shreg = reg_rdata;
         n.sda_low = !reg_rdata[7];
         n.rd_stb = 1'b1;
         n.bit_cnt = 4'h0;
         n.st = DS_TX;
      end
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         r <= SCP_DEV_RST;
      end
      else
      begin
         r <= n;
      end
   end

   // ====================================================================
   // Outputs; the data line is only ever pulled low, the clock never
   assign bus.sda_s_o = 1'b0;
   assign bus.sda_s_oe = r.sda_low;
   assign four_wire_sel = !i2c_en;
   assign sleep_active = !r.slp_s2;
   assign reg_addr = r.ptr;
   assign reg_wdata = r.wdata;
   assign reg_wr_stb = r.wr_stb;
   assign reg_rd_stb = r.rd_stb;
endmodule

// ==== verilog/scp_host.sv ====
// Master end of the two-wire serial control port
`timescale 1ns/1ps
module scp_host
   import scp_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   scp_if.host bus,
   input wire logic cmd_valid,
   output logic cmd_ready,
   input wire logic cmd_start,
   input wire logic cmd_stop,
   input wire logic cmd_read,
   input wire logic cmd_ack,
   input wire logic [7:0] cmd_wdata,
   output logic rsp_valid,
   output logic [7:0] rsp_data,
   output logic rsp_nack
);
   // ====================================================================
   // State
   typedef enum logic [2:0] {HS_IDLE, HS_HOLD, HS_START, HS_BIT, HS_STOP} scp_host_st_t;

   typedef struct packed {
      logic sda_s1;
      logic sda_s2;
      scp_host_st_t st;
      logic [1:0] q;
      logic [7:0] tick;
      logic [3:0] bit_cnt;
      logic [7:0] shreg;
      logic rd;
      logic ack;
      logic stop;
      logic scl_low;
      logic sda_low;
      logic rsp_valid;
      logic [7:0] rsp_data;
      logic rsp_nack;
   } scp_host_reg_t;

   scp_host_reg_t r;
   scp_host_reg_t n;
   logic qend;
   logic waiting;

   assign qend = (r.tick == SCP_QUARTER_LAST);
   assign waiting = (r.st == HS_IDLE) || (r.st == HS_HOLD);

   // ====================================================================
   // Each bit is four quarter periods; actions land at quarter ends
   always_comb
   begin
      n = r;
      n.sda_s1 = bus.sda;
      n.sda_s2 = r.sda_s1;
      n.rsp_valid = 1'b0;
      if (!waiting)
      begin
         n.tick = qend ? 8'h00 : r.tick + 8'h01;
      end
      if (!waiting && qend)
      begin
         n.q = r.q + 2'h1;
      end
      case (r.st)
         HS_IDLE, HS_HOLD:
         begin
            if (cmd_valid)
            begin
               n.rd = cmd_read;
               n.ack = cmd_ack;
               n.stop = cmd_stop;
               n.shreg = cmd_wdata;
               n.q = 2'h0;
               n.tick = 8'h00;
               n.bit_cnt = 4'h0;
               // An idle bus always needs a start first
               n.st = (cmd_start || r.st == HS_IDLE) ? HS_START : HS_BIT;
            end
         end
         HS_START:
         begin
            if (qend)
            begin
               case (r.q)
                  2'h0: n.sda_low = 1'b0;
                  2'h1: n.scl_low = 1'b0;
                  2'h2: n.sda_low = 1'b1;
                  default:
                  begin
                     n.scl_low = 1'b1;
                     n.st = HS_BIT;
                  end
               endcase
            end
         end
         HS_BIT:
         begin
            if (qend)
            begin
               case (r.q)
                  2'h0:
                  begin
                     if (r.bit_cnt == SCP_BITS_PER_BYTE)
                     begin
                        n.sda_low = r.rd && r.ack;
                     end
                     else
                     begin
                        n.sda_low = !r.rd && !r.shreg[7];
                     end
                  end
                  2'h1: n.scl_low = 1'b0;
                  2'h2:
                  begin
                     if (r.bit_cnt == SCP_BITS_PER_BYTE)
                     begin
                        n.rsp_nack = r.sda_s2;
                     end
                     else
                     begin
                        n.shreg = {r.shreg[6:0], r.sda_s2};
                     end
                  end
                  default:
                  begin
                     n.scl_low = 1'b1;
                     if (r.bit_cnt == SCP_BITS_PER_BYTE)
                     begin
                        n.rsp_valid = 1'b1;
                        n.rsp_data = r.shreg;
                        n.st = r.stop ? HS_STOP : HS_HOLD;
                     end
                     else
                     begin
                        n.bit_cnt = r.bit_cnt + 4'h1;
                     end
                  end
               endcase
            end
         end
         HS_STOP:
         begin
            if (qend)
            begin
               case (r.q)
                  2'h0: n.sda_low = 1'b1;
                  2'h1: n.scl_low = 1'b0;
                  2'h2: n.sda_low = 1'b0;
                  default: n.st = HS_IDLE;
               endcase
            end
         end
         default:
         begin
            n.st = HS_IDLE;
         end
      endcase
   end

   always_ff @(posedge ref_clk)
   begin
      if (rst)
      begin
         r <= '0;
      end
      else
      begin
         r <= n;
      end
   end

   // ====================================================================
   // Outputs
   assign cmd_ready = waiting;
   assign bus.scl_o = 1'b0;
   assign bus.scl_oe = r.scl_low;
   assign bus.sda_m_o = 1'b0;
   assign bus.sda_m_oe = r.sda_low;
   assign rsp_valid = r.rsp_valid;
   assign rsp_data = r.rsp_data;
   assign rsp_nack = r.rsp_nack;
endmodule

// ==== testbench/scp_bus_sva.sv ====
// Checker of the two-wire bus between the host and device ends
`timescale 1ns/1ps
module scp_bus_sva
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic sda_s_o,
   input wire logic sda_s_oe,
   input wire logic scl,
   input wire logic sda
);
   default clocking cb @(posedge ref_clk);
   endclocking
   default disable iff (rst);
   // ====================================================================
   // Device drive on SDA
   property p_dev_open_drain;
      sda_s_oe |-> !sda_s_o;
   endproperty
   a_dev_open_drain: assert property (p_dev_open_drain) else $error("device sda not open drain");
   property p_dev_chg_low;
      $changed(sda_s_oe) |-> !scl && !$past(scl);
   endproperty
   a_dev_chg_low: assert property (p_dev_chg_low) else $error("device sda moved while scl high");
   // Synchronised edges put the device change a few cycles after the fall, well inside the low phase
   property p_dev_after_fall;
      $changed(sda_s_oe) |-> $past(scl, 8);
   endproperty
   a_dev_after_fall: assert property (p_dev_after_fall) else $error("device sda moved late");
   property p_dev_bit_stands;
      $rose(sda_s_oe) |-> sda_s_oe [*8];
   endproperty
   a_dev_bit_stands: assert property (p_dev_bit_stands) else $error("device low bit too short");
   // ====================================================================
   // Conditions and clock shape
   property p_start_quiet;
      scl && $fell(sda) |-> !sda_s_oe [*8];
   endproperty
   a_start_quiet: assert property (p_start_quiet) else $error("device drives at start");
   property p_stop_quiet;
      scl && $rose(sda) |-> !sda_s_oe [*8];
   endproperty
   a_stop_quiet: assert property (p_stop_quiet) else $error("device drives at stop");
   property p_scl_high_min;
      $rose(scl) |-> scl [*8];
   endproperty
   a_scl_high_min: assert property (p_scl_high_min) else $error("scl high too short");
   property p_scl_low_min;
      $fell(scl) |-> !scl [*8];
   endproperty
   a_scl_low_min: assert property (p_scl_low_min) else $error("scl low too short");
endmodule

// ==== testbench/tb_serial_control_port_i2c_slave.sv ====
// Bench joining the host and device ends of the serial control port
`timescale 1ns/1ps
module tb_serial_control_port_i2c_slave;
   import scp_pkg::*;
   localparam logic Y = 1'b1;
   localparam logic N = 1'b0;
   logic ref_clk = 1'b0;
   logic rst = 1'b1;
   logic [1:0] strap_u = 2'h0;
   logic [1:0] strap_l = 2'h0;
   logic sleep_n = 1'b1;
   logic four_wire_sel, sleep_active, reg_wr_stb, reg_rd_stb;
   logic [15:0] reg_addr, last_waddr;
   logic [7:0] reg_wdata, reg_rdata, rsp_data, got;
   logic cmd_valid = 1'b0;
   logic cmd_ready, cmd_start, cmd_stop, cmd_read, cmd_ack, rsp_valid, rsp_nack, nak;
   logic [7:0] cmd_wdata;
   logic [7:0] mem [0:255];
   int fail_count = 0;
   int comparisons = 0;
   int cycles = 0;
   int wr_count = 0;
   int rd_count = 0;
   scp_if bus_if();
   always #12.5 ref_clk = ~ref_clk;
   assign reg_rdata = mem[reg_addr[7:0]];
   scp_dev scp_dev_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus_if.dev), .port_strap_upper(strap_u),
      .port_strap_lower(strap_l), .sleep_request_n(sleep_n), .four_wire_sel(four_wire_sel),
      .sleep_active(sleep_active), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr_stb(reg_wr_stb),
      .reg_rd_stb(reg_rd_stb), .reg_rdata(reg_rdata));
   scp_host scp_host_inst (.ref_clk(ref_clk), .rst(rst), .bus(bus_if.host), .cmd_valid(cmd_valid),
      .cmd_ready(cmd_ready), .cmd_start(cmd_start), .cmd_stop(cmd_stop), .cmd_read(cmd_read),
      .cmd_ack(cmd_ack), .cmd_wdata(cmd_wdata), .rsp_valid(rsp_valid), .rsp_data(rsp_data), .rsp_nack(rsp_nack));
   scp_bus_sva scp_bus_sva_inst (.ref_clk(ref_clk), .rst(rst), .sda_s_o(bus_if.sda_s_o),
      .sda_s_oe(bus_if.sda_s_oe), .scl(bus_if.scl), .sda(bus_if.sda));
   // ====================================================================
   // Register file beside the device, and the run limit
   always @(posedge ref_clk)
   begin
      cycles <= cycles + 1;
      if (reg_wr_stb === 1'b1)
      begin
         mem[reg_addr[7:0]] <= reg_wdata;
         last_waddr <= reg_addr;
         wr_count <= wr_count + 1;
      end
      if (reg_rd_stb === 1'b1)
         rd_count <= rd_count + 1;
      if (cycles == 40000)
      begin
         fail_count++;
         print_verdict();
      end
   end
   // ====================================================================
   // Shared tasks
   task automatic print_verdict();
      $display("Comparisons %0d, mismatches %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0)
         $display("DONE - PASS");
      else
         $display("DONE - FAIL");
      $finish;
   endtask
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      comparisons++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("Error at %0t: seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic do_reset();
      @(negedge ref_clk);
      // Let a pending stop finish so reset never cuts a frame in half
      while (cmd_ready !== 1'b1)
         @(negedge ref_clk);
      rst = 1'b1;
      repeat (8) @(negedge ref_clk);
      rst = 1'b0;
      repeat (4) @(negedge ref_clk);
   endtask
   // One byte on the bus; the host command is offered for one cycle once ready is seen
   task automatic xfer(input logic st, input logic sp, input logic rd, input logic ak, input logic [7:0] wd);
      int n;
      n = 0;
      @(negedge ref_clk);
      while (cmd_ready !== 1'b1 && n < 2000)
      begin
         @(negedge ref_clk);
         n++;
      end
      cmd_valid = 1'b1;
      {cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_wdata} = {st, sp, rd, ak, wd};
      @(negedge ref_clk);
      cmd_valid = 1'b0;
      n = 0;
      while (rsp_valid !== 1'b1 && n < 2000)
      begin
         @(negedge ref_clk);
         n++;
      end
      check(16'(n < 2000), 16'h0001);
      got = rsp_data;
      nak = rsp_nack;
   endtask
   task automatic wbyte(input logic st, input logic sp, input logic [7:0] wd);
      xfer(st, sp, N, N, wd);
      check(16'(nak), 16'h0000);
   endtask
   // ====================================================================
   // Scenarios
   task automatic s_addr_table();
      logic [6:0] own;
      for (int u = 0; u < 3; u++)
         for (int l = 0; l < 3; l++)
         begin
            strap_u = 2'(u);
            strap_l = 2'(l);
            do_reset();
            own = {4'hB, 3'(3 * u + l)};
            check(16'(four_wire_sel), 16'(u == 2 && l == 2));
            xfer(Y, N, N, N, {own, SCP_DIR_WRITE});
            check(16'(nak), 16'(u == 2 && l == 2));
            // Repeated start with a foreign address must be refused
            xfer(Y, Y, N, N, {own ^ 7'h08, SCP_DIR_WRITE});
            check(16'(nak), 16'h0001);
         end
      strap_u = 2'h0;
      strap_l = 2'h0;
      do_reset();
   endtask
   task automatic s_write();
      int base;
      base = wr_count;
      sleep_n = 1'b0;
      wbyte(Y, N, 8'hB0);
      check(16'(sleep_active), 16'h0001);
      wbyte(N, N, 8'h12);
      wbyte(N, N, 8'h40);
      check(16'(wr_count - base), 16'h0000);
      for (int i = 0; i < 3; i++)
         wbyte(N, i == 2, 8'(8'h11 * (i + 1)));
      check(16'(wr_count - base), 16'h0003);
      check(last_waddr, 16'h1242);
      check({mem[8'h40], mem[8'h42]}, 16'h1133);
      sleep_n = 1'b1;
   endtask
   task automatic s_read();
      int base;
      base = rd_count;
      wbyte(Y, N, 8'hB0);
      wbyte(N, N, 8'h12);
      wbyte(N, N, 8'h40);
      wbyte(Y, N, 8'hB1);
      for (int i = 0; i < 3; i++)
      begin
         xfer(N, i == 2, Y, i != 2, 8'hFF);
         check(16'(got), 16'(8'h11 * (i + 1)));
         check(16'(nak), 16'(i == 2));
      end
      check(16'(rd_count - base), 16'h0003);
      check(16'(bus_if.sda), 16'h0001);
      // Plain read continues from the pointer left by the burst
      wbyte(Y, N, 8'hB1);
      xfer(N, Y, Y, N, 8'hFF);
      check(16'(got), 16'h0019);
      check(reg_addr, 16'h1244);
   endtask
   initial
   begin
      for (int i = 0; i < 256; i++)
         mem[i] = 8'(i) ^ 8'h5A;
      {cmd_start, cmd_stop, cmd_read, cmd_ack, cmd_wdata} = 12'h000;
      do_reset();
      s_addr_table();
      s_write();
      s_read();
      print_verdict();
   end
endmodule
